// >>> core/acr_pkg.sv
// constants, register map and carrier types for the converter control block
//
// Behaviour
// - Analog-enable bits 3:0 make matching port-5 pins analog inputs when set.
// - Control bit 7 picks reference: 0 supply and port pin, 1 shared pin.
// - Shared pin priority: reference highest, timer clock middle, port I/O lowest.
// - Clock field 6:5 selects divide by 4, 16, 64 or ring oscillator.
// - Writing 1 to run bit 4 starts one conversion on selected channel.
// - Hardware clears run bit at completion; software writing 0 does nothing.
// - Power bit 3: 1 converter operates, 0 reference network switched off.
// - Channel field 1:0 selects analog pin 0 to 3 in order.
// - Channel changes only while done flag and run bit are both low.
// - Calibration bit 7 enables offset correction when set.
// - Calibration bit 6 gives correction sign: 0 negative, 1 positive.
// - Offset field 5:3 selects correction in two-LSB steps, 0 to 14.
// - Calibration bits 2:0 are unimplemented and read zero.
// - Completion loads result, clears run bit and sets done flag together.
// - Upper result register reads result bits 11:4.
// - High nibble register holds bits 11:8, low byte register bits 7:0.
// - Done flag bit 5 set by hardware, cleared by software writing 0 to it, never set by software.
// - Status register reads as its contents ANDed with the mask register.
// - Wake enable bit 3 lets a completed conversion wake the chip.
// - Wake enable bit 1 lets a port-5 input change wake the chip.
// - Status bits 7,6,4,2,0 and select bits 7:4 read zero.
package acr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [4:0] ACR_ADDR_PIN_SEL = 5'h00;
    localparam logic [4:0] ACR_ADDR_CTRL = 5'h04;
    localparam logic [4:0] ACR_ADDR_CAL = 5'h08;
    localparam logic [4:0] ACR_ADDR_RES_UP = 5'h0C;
    localparam logic [4:0] ACR_ADDR_RES_HI = 5'h10;
    localparam logic [4:0] ACR_ADDR_RES_LO = 5'h14;
    localparam logic [4:0] ACR_ADDR_STATUS = 5'h18;
    localparam logic [4:0] ACR_ADDR_MASK = 5'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ACR_CTRL_REF_BIT = 7;
    localparam int ACR_CTRL_DIV_LO = 5;
    localparam int ACR_CTRL_RUN_BIT = 4;
    localparam int ACR_CTRL_PWR_BIT = 3;
    localparam int ACR_CTRL_CH_LO = 0;
    localparam int ACR_CAL_EN_BIT = 7;
    localparam int ACR_CAL_SIGN_BIT = 6;
    localparam int ACR_CAL_MAG_LO = 3;
    localparam int ACR_ST_DONE_BIT = 5;
    localparam int ACR_ST_CWAKE_BIT = 3;
    localparam int ACR_ST_PWAKE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0] ACR_PIN_SEL_RST = 4'h0;
    localparam logic [1:0] ACR_DIV_RST = 2'h0;
    localparam logic [7:0] ACR_MASK_RST = 8'h00;
    localparam logic [11:0] ACR_RESULT_RST = 12'h000;

    ////////////////////////////////////////////////////////////////////////////
    // clock divider codes
    localparam logic [1:0] ACR_DIV_4 = 2'h0;
    localparam logic [1:0] ACR_DIV_16 = 2'h1;
    localparam logic [1:0] ACR_DIV_64 = 2'h2;
    localparam logic [1:0] ACR_DIV_RING = 2'h3;

    typedef enum logic [1:0] {
        ACR_ST_IDLE = 2'b00,
        ACR_ST_BUSY = 2'b01
    } acr_state_t;

    // request toward the analog core
    typedef struct packed {
        logic start;
        logic [1:0] channel;
        logic [1:0] clk_div;
        logic power_on;
        logic ref_from_pin;
        logic offset_en;
        logic offset_positive;
        logic [2:0] offset_magnitude;
    } acr_core_req_t;

    // answer from the analog core
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } acr_core_rsp_t;

    // pin function steering
    typedef struct packed {
        logic [3:0] analog_enable;
        logic shared_is_ref;
        logic shared_is_timer;
        logic shared_is_port;
    } acr_pin_ctl_t;

endpackage

// >>> core/acr_top.sv
// converter control registers with classic wishbone slave
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
(
    input wire logic clk_i,                 // core clock
    input wire logic rst_i,                 // synchronous reset, high
    input wire logic wb_cyc_i,              // bus cycle
    input wire logic wb_stb_i,              // strobe
    input wire logic wb_we_i,               // write enable
    input wire logic [4:0] wb_adr_i,        // byte address
    input wire logic [3:0] wb_sel_i,        // byte lanes
    input wire logic [31:0] wb_dat_i,       // write data
    output logic [31:0] wb_dat_o,           // read data
    output logic wb_ack_o,                  // acknowledge
    input wire acr_core_rsp_t core_rsp_i,   // done strobe and result
    output acr_core_req_t core_req_o,       // controls to analog core
    input wire logic timer_source_sel_i,    // timer source select from timer block
    input wire logic port_change_i,         // port-5 change level from pins
    output acr_pin_ctl_t pin_ctl_o,         // pin function steering
    output logic wake_o                     // wake request to sleep control
);

    typedef struct packed {
        acr_state_t state;
        logic [3:0] pin_sel;
        logic ref_sel;
        logic [1:0] div;
        logic power_on;
        logic [1:0] channel;
        logic cal_en;
        logic cal_sign;
        logic [2:0] cal_mag;
        logic [11:0] result;
        logic done_flag;
        logic conv_wake_en;
        logic port_wake_en;
        logic [7:0] mask;
        logic start;
        logic ack;
        logic [7:0] rdata;
        logic [1:0] chg_sync;
    } acr_regs_t;

    acr_regs_t r_reg;
    acr_regs_t r_next;
    logic [7:0] wbyte;
    logic req;
    logic wr;
    logic [7:0] status_raw;
    logic running;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    assign req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign running = (r_reg.state == ACR_ST_BUSY);

    always_comb begin
        status_raw = 8'h00; // unused bits stay zero
        status_raw[ACR_ST_DONE_BIT] = r_reg.done_flag;
        status_raw[ACR_ST_CWAKE_BIT] = r_reg.conv_wake_en;
        status_raw[ACR_ST_PWAKE_BIT] = r_reg.port_wake_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.ack = req;
        r_next.chg_sync = {r_reg.chg_sync[0], port_change_i};

        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ACR_ADDR_PIN_SEL: begin
                    r_next.rdata = {4'h0, r_reg.pin_sel};
                end
                ACR_ADDR_CTRL: begin
                    r_next.rdata = {r_reg.ref_sel, r_reg.div, running, r_reg.power_on, 1'b0, r_reg.channel};
                end
                ACR_ADDR_CAL: begin
                    r_next.rdata = {r_reg.cal_en, r_reg.cal_sign, r_reg.cal_mag, 3'h0};
                end
                ACR_ADDR_RES_UP: begin
                    r_next.rdata = r_reg.result[11:4];
                end
                ACR_ADDR_RES_HI: begin
                    r_next.rdata = {4'h0, r_reg.result[11:8]};
                end
                ACR_ADDR_RES_LO: begin
                    r_next.rdata = r_reg.result[7:0];
                end
                ACR_ADDR_STATUS: begin
                    r_next.rdata = status_raw & r_reg.mask;
                end
                ACR_ADDR_MASK: begin
                    r_next.rdata = r_reg.mask;
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end

        if (wr) begin
            case (wb_adr_i)
                ACR_ADDR_PIN_SEL: begin
                    r_next.pin_sel = wbyte[3:0];
                end
                ACR_ADDR_CTRL: begin
                    r_next.ref_sel = wbyte[ACR_CTRL_REF_BIT];
                    r_next.div = wbyte[ACR_CTRL_DIV_LO +: 2];
                    r_next.power_on = wbyte[ACR_CTRL_PWR_BIT];
                    if (!r_reg.done_flag && !running) begin
                        r_next.channel = wbyte[ACR_CTRL_CH_LO +: 2];
                    end
                    // a zero leaves the run bit alone
                    if (wbyte[ACR_CTRL_RUN_BIT] && !running) begin
                        r_next.state = ACR_ST_BUSY;
                        r_next.start = 1'b1;
                    end
                end
                ACR_ADDR_CAL: begin
                    r_next.cal_en = wbyte[ACR_CAL_EN_BIT];
                    r_next.cal_sign = wbyte[ACR_CAL_SIGN_BIT];
                    r_next.cal_mag = wbyte[ACR_CAL_MAG_LO +: 3];
                end
                ACR_ADDR_STATUS: begin
                    if (!wbyte[ACR_ST_DONE_BIT]) begin
                        r_next.done_flag = 1'b0;
                    end
                    r_next.conv_wake_en = wbyte[ACR_ST_CWAKE_BIT];
                    r_next.port_wake_en = wbyte[ACR_ST_PWAKE_BIT];
                end
                ACR_ADDR_MASK: begin
                    r_next.mask = wbyte;
                end
                default: begin
                    r_next.mask = r_reg.mask;
                end
            endcase
        end

        // completion after any software clear, so the set wins
        case (r_reg.state)
            ACR_ST_BUSY: begin
                if (core_rsp_i.done) begin
                    r_next.result = core_rsp_i.result;
                    r_next.state = ACR_ST_IDLE;
                    r_next.done_flag = 1'b1;
                end
            end
            ACR_ST_IDLE: begin
                r_next.state = r_next.state;
            end
            default: begin
                r_next.state = ACR_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.state <= ACR_ST_IDLE;
            r_reg.pin_sel <= ACR_PIN_SEL_RST;
            r_reg.div <= ACR_DIV_RST;
            r_reg.mask <= ACR_MASK_RST;
            r_reg.result <= ACR_RESULT_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o = r_reg.ack;
    assign wb_dat_o = {24'h000000, r_reg.rdata};

    always_comb begin
        core_req_o.start = r_reg.start;
        core_req_o.channel = r_reg.channel;
        core_req_o.clk_div = r_reg.div;
        core_req_o.power_on = r_reg.power_on;
        core_req_o.ref_from_pin = r_reg.ref_sel;
        core_req_o.offset_en = r_reg.cal_en;
        core_req_o.offset_positive = r_reg.cal_sign;
        core_req_o.offset_magnitude = r_reg.cal_mag;
        pin_ctl_o.analog_enable = r_reg.pin_sel;
        // reference beats timer clock beats port I/O
        pin_ctl_o.shared_is_ref = r_reg.ref_sel;
        pin_ctl_o.shared_is_timer = ~r_reg.ref_sel & timer_source_sel_i;
        pin_ctl_o.shared_is_port = ~r_reg.ref_sel & ~timer_source_sel_i;
    end

    assign wake_o = (r_reg.done_flag & r_reg.conv_wake_en) | (r_reg.chg_sync[1] & r_reg.port_wake_en);

endmodule

// >>> tb/acr_core_model.sv
// behavioural analog core answering start pulses
`timescale 1ns/1ps
module acr_core_model
    import acr_pkg::*;
#(
    parameter int DELAY = 20
)
(
    input wire logic clk_i,               // clock
    input wire logic rst_i,               // reset
    input wire acr_core_req_t core_req_i, // controls
    input wire logic [11:0] result_i,     // value to return
    output acr_core_rsp_t core_rsp_o      // done and result
);
    int cnt;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            core_rsp_o <= '0;
        end else if (core_req_i.start) begin
            // result lines churn outside the done strobe
            core_rsp_o <= {1'b0, ~core_rsp_o.result};
            cnt <= DELAY;
        end else if (cnt == 1) begin
            core_rsp_o <= {1'b1, result_i};
            cnt <= 0;
        end else begin
            core_rsp_o <= {1'b0, ~core_rsp_o.result};
            if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> tb/acr_top_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module acr_top_chk
    import acr_pkg::*;
(
    input wire logic clk_i,              // clk
    input wire logic rst_i,              // rst
    input wire logic wb_cyc_i,           // bus
    input wire logic wb_stb_i,           // bus
    input wire logic wb_we_i,            // bus
    input wire logic [4:0] wb_adr_i,     // bus
    input wire logic [3:0] wb_sel_i,     // bus
    input wire logic [31:0] wb_dat_i,    // bus
    input wire logic [31:0] wb_dat_o,    // bus
    input wire logic wb_ack_o,           // bus
    input wire acr_core_rsp_t core_rsp_i, // core
    input wire acr_core_req_t core_req_o, // core
    input wire logic timer_source_sel_i, // timer
    input wire logic port_change_i,      // pins
    input wire acr_pin_ctl_t pin_ctl_o,  // pins
    input wire logic wake_o              // wake
);
    logic busy_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
        end else if (core_req_o.start) begin
            busy_reg <= 1'b1;
        end else if (core_rsp_i.done) begin
            busy_reg <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_run_wr;
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == ACR_ADDR_CTRL && wb_dat_i[4]);
    endsequence
    AST_ACK_REQ: assert property (s_take |=> wb_ack_o) else $error("no ack");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_START_GO: assert property (s_run_wr ##0 !busy_reg |=> core_req_o.start)
        else $error("no start");
    AST_START_ONE: assert property (core_req_o.start |=> !core_req_o.start [*2])
        else $error("start too long");
    AST_NO_RESTART: assert property (busy_reg |-> !core_req_o.start) else $error("restart");
    AST_CH_HOLD: assert property (busy_reg |=> $stable(core_req_o.channel))
        else $error("channel moved");
    AST_REF_PIN: assert property (pin_ctl_o.shared_is_ref == core_req_o.ref_from_pin)
        else $error("reference steering");
    AST_PRIO: assert property ($onehot({pin_ctl_o.shared_is_ref, pin_ctl_o.shared_is_timer,
        pin_ctl_o.shared_is_port}) && (pin_ctl_o.shared_is_ref || pin_ctl_o.shared_is_timer == timer_source_sel_i))
        else $error("shared pin priority");
    AST_CAL_ZERO: assert property (wb_ack_o && $past(wb_adr_i == ACR_ADDR_CAL && !wb_we_i) |->
        wb_dat_o[2:0] == 3'h0) else $error("calibration low bits");
    AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits");
endmodule

// >>> tb/tb.sv
// register level bench for the converter control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    import acr_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tsel, pchg, wake_o;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i, lanes;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] q;
    logic [11:0] res;
    acr_core_rsp_t rsp;
    acr_core_req_t req;
    acr_pin_ctl_t pins;
    int bad_count, n_tests, cycles;
    acr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_rsp_i(rsp), .core_req_o(req), .timer_source_sel_i(tsel), .port_change_i(pchg),
        .pin_ctl_o(pins), .wake_o(wake_o));
    acr_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .core_req_i(req), .result_i(res), .core_rsp_o(rsp));
    always #10 clk_i = ~clk_i;
    task automatic xfer(input logic we, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= lanes;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK($sformatf("reg %h", a), e, q)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, tsel, pchg, wb_adr_i, wb_dat_i} = '0;
        rst_i = 1'b1;
        lanes = 4'hF;
        wb_sel_i = 4'hF;
        res = 12'hB7D;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rc(5'(i * 4), 8'h00);
        xfer(1'b1, ACR_ADDR_PIN_SEL, 8'hFF);
        rc(ACR_ADDR_PIN_SEL, 8'h0F);
        `CHK("analog_enable", 4'hF, pins.analog_enable)
        // lane 0 off: the write is acked but must not land
        lanes = 4'hE;
        xfer(1'b1, ACR_ADDR_PIN_SEL, 8'h00);
        lanes = 4'hF;
        rc(ACR_ADDR_PIN_SEL, 8'h0F);
        rc(5'h01, 8'h00);
        xfer(1'b1, ACR_ADDR_CAL, 8'hFF);
        rc(ACR_ADDR_CAL, 8'hF8);
        xfer(1'b1, ACR_ADDR_CAL, 8'h68);
        `CHK("offset", 5'h0D, {req.offset_en, req.offset_positive, req.offset_magnitude})
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ACR_ADDR_CTRL, 8'h08 | 8'(i * 33));
            `CHK("clk_div", 2'(i), req.clk_div)
            `CHK("channel", 2'(i), req.channel)
            `CHK("power", 1'b1, req.power_on)
        end
        xfer(1'b1, ACR_ADDR_CTRL, 8'h80);
        `CHK("shared", 3'b100, {pins.shared_is_ref, pins.shared_is_timer, pins.shared_is_port})
        xfer(1'b1, ACR_ADDR_CTRL, 8'h00);
        tsel <= 1'b1;
        @(posedge clk_i);
        `CHK("shared", 3'b010, {pins.shared_is_ref, pins.shared_is_timer, pins.shared_is_port})
        `CHK("power", 1'b0, req.power_on)
        tsel <= 1'b0;
        xfer(1'b1, ACR_ADDR_MASK, 8'hFF);
        xfer(1'b1, ACR_ADDR_CTRL, 8'h1A);
        rc(ACR_ADDR_CTRL, 8'h1A);
        xfer(1'b1, ACR_ADDR_CTRL, 8'h09);
        rc(ACR_ADDR_CTRL, 8'h1A);
        for (int k = 0; k < 40 && q[4]; k++) xfer(1'b0, ACR_ADDR_CTRL, 8'h00);
        rc(ACR_ADDR_CTRL, 8'h0A);
        rc(ACR_ADDR_STATUS, 8'h20);
        rc(ACR_ADDR_RES_UP, 8'hB7);
        rc(ACR_ADDR_RES_HI, 8'h0B);
        rc(ACR_ADDR_RES_LO, 8'h7D);
        xfer(1'b1, ACR_ADDR_CTRL, 8'h09);
        rc(ACR_ADDR_CTRL, 8'h0A);
        xfer(1'b1, ACR_ADDR_STATUS, 8'h28);
        `CHK("wake", 1'b1, wake_o)
        xfer(1'b1, ACR_ADDR_STATUS, 8'h02);
        rc(ACR_ADDR_STATUS, 8'h02);
        `CHK("wake", 1'b0, wake_o)
        pchg <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("wake", 1'b1, wake_o)
        pchg <= 1'b0;
        xfer(1'b1, ACR_ADDR_STATUS, 8'hFF);
        rc(ACR_ADDR_STATUS, 8'h0A);
        xfer(1'b1, ACR_ADDR_MASK, 8'h08);
        rc(ACR_ADDR_STATUS, 8'h08);
        // second reset after the conversion has finished must bring control, pin select, status and wake back
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(ACR_ADDR_CTRL, 8'h00);
        rc(ACR_ADDR_PIN_SEL, 8'h00);
        rc(ACR_ADDR_STATUS, 8'h00);
        `CHK("wake", 1'b0, wake_o)
        end_of_test();
    end
endmodule
bind acr_top acr_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_rsp_i(core_rsp_i), .core_req_o(core_req_o), .timer_source_sel_i(timer_source_sel_i),
    .port_change_i(port_change_i), .pin_ctl_o(pin_ctl_o), .wake_o(wake_o));
